/* File: emb_params.svh */
/*
 * Constants of the embedded memory block: register offsets, field
 * positions, reset values and sizes.
 * Assumes it is included by bare name from the block's design files.
 */
// Functional notes
// - Block shapes 256x8, 512x4, 1024x2, 2048x1
// - Two same-shape blocks combine into wider word
// - Blocks cascade in depth except in 2048x1, no added latency
// - Internal write pulse timed from input clock
// - Input and output registers on independent clocks
// - Data, address+enable, output registering each selectable
// - Write enable from global or local source
// - Lookup mode returns preloaded read-only words
`ifndef EMB_PARAMS_SVH
`define EMB_PARAMS_SVH

// Register byte offsets
`define EMB_OFS_CFG        8'h00
`define EMB_OFS_STATUS     8'h04
`define EMB_OFS_LOAD_ADDR  8'h08
`define EMB_OFS_LOAD_DATA  8'h0C

// Configuration fields
`define EMB_CFG_SHAPE_LO   0
`define EMB_CFG_SHAPE_HI   1
`define EMB_CFG_DEEP       2
`define EMB_CFG_DATA_REG   3
`define EMB_CFG_ADDR_REG   4
`define EMB_CFG_OUT_REG    5
`define EMB_CFG_WE_GLOBAL  6
`define EMB_CFG_LOOKUP     7
`define EMB_CFG_RESET      8'h00

// Status fields
`define EMB_ST_LOOKUP      16

// Sizes
`define EMB_BLOCKS         2
`define EMB_BLOCK_BITS     2048
`define EMB_AW             11
`define EMB_LANES          8
`define EMB_WW             16

`endif

/* File: emb_pkg.sv */
/*
 * Types of the embedded memory block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package emb_pkg;

	// Depth-by-width shape of one block
	typedef enum logic [1:0] {
		SHAPE_256X8,
		SHAPE_512X4,
		SHAPE_1024X2,
		SHAPE_2048X1
	} emb_shape_t;

endpackage

/* File: emb_ram_array.sv */
/*
 * One embedded memory block: 2048 flip-flop bits seen as a word array
 * of the selected shape, one write port and one combinational read port.
 * Assumes write address, data and pulse are stable around the clock edge.
 */
`timescale 1ns/10ps
`include "emb_params.svh"

module emb_ram_array (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// Shape of the block
	input  wire emb_pkg::emb_shape_t    shape,
	// Write port
	input  wire logic [`EMB_AW-1:0]     waddr,
	input  wire logic [`EMB_LANES-1:0]  wdata,
	input  wire logic                   we,
	// Read port
	input  wire logic [`EMB_AW-1:0]     raddr,
	output logic [`EMB_LANES-1:0]       rdata
);

	logic [`EMB_BLOCK_BITS-1:0] mem;        // Storage bits
	logic [`EMB_AW-1:0]         wbase;      // First bit of written word
	logic [`EMB_AW-1:0]         rbase;      // First bit of read word
	logic [`EMB_LANES-1:0]      lane_mask;  // Lanes used by this shape

	// First bit of a word: address scaled by word width
	function automatic logic [`EMB_AW-1:0] base_of(input emb_pkg::emb_shape_t s,
		input logic [`EMB_AW-1:0] a);
		logic [`EMB_AW-1:0] b;
		b = a;
		unique case (s)
			emb_pkg::SHAPE_256X8:  b = {a[7:0], 3'h0};
			emb_pkg::SHAPE_512X4:  b = {a[8:0], 2'h0};
			emb_pkg::SHAPE_1024X2: b = {a[9:0], 1'h0};
			emb_pkg::SHAPE_2048X1: b = a;
		endcase
		return b;
	endfunction

	// Word layout per shape
	assign wbase = base_of(shape, waddr);
	assign rbase = base_of(shape, raddr);
	assign lane_mask = (shape == emb_pkg::SHAPE_256X8)  ? 8'hFF :
	                   (shape == emb_pkg::SHAPE_512X4)  ? 8'h0F :
	                   (shape == emb_pkg::SHAPE_1024X2) ? 8'h03 : 8'h01;

	// Write the used lanes on the internal pulse
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem <= '0;
		end else begin
			for (int i = 0; i < `EMB_LANES; i++) begin
				if (we && lane_mask[i]) begin
					mem[wbase + i[`EMB_AW-1:0]] <= wdata[i];
				end
			end
		end
	end

	// Read lanes, unused lanes read zero
	genvar gi;
	generate
		for (gi = 0; gi < `EMB_LANES; gi++) begin : g_lane
			assign rdata[gi] = lane_mask[gi] & mem[rbase + 11'(gi)];
		end
	endgenerate

	// Word base follows shape
	a_bit_base: assert property (@(posedge clk) disable iff (!rst_n)
		(shape == emb_pkg::SHAPE_512X4) |-> (wbase == {waddr[8:0], 2'h0} && lane_mask == 8'h0F))
		else $error("word base wrong for 512x4");

endmodule // emb_ram_array

/* File: emb_mem_block.sv */
/*
 * Configurable embedded memory: two blocks combined wide or deep,
 * RAM or lookup mode, selectable input and output registering,
 * APB slave for configuration and lookup loading.
 * Assumes user logic on clk for address, data and write enables;
 * out_clk may be any independent clock for the output register.
 */
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "emb_params.svh"

module emb_mem_block (
	// Clocks and reset
	input  wire logic                clk,
	input  wire logic                out_clk,
	input  wire logic                nrst,
	// APB slave
	input  wire logic [7:0]          paddr,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [31:0]         pwdata,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	// User memory port
	input  wire logic [`EMB_AW-1:0]  user_addr,
	input  wire logic [`EMB_WW-1:0]  user_wdata,
	input  wire logic                user_we,
	input  wire logic                user_we_global,
	output logic [`EMB_WW-1:0]       user_rdata
);

	// Reset synchronisers
	logic rs1, rst_n;          // Input-side reset copy
	logic ors1, orst_n;        // Output-side reset copy

	// Registers
	logic [7:0]         cfg;        // Configuration
	logic [`EMB_AW-1:0] load_addr;  // Lookup load pointer
	logic [15:0]        load_data;  // Last loaded word
	logic [15:0]        wr_count;   // Internal write pulses seen

	// Configuration fields
	emb_pkg::emb_shape_t shape;
	wire cfg_deep     = cfg[`EMB_CFG_DEEP];
	wire cfg_data_reg = cfg[`EMB_CFG_DATA_REG];
	wire cfg_addr_reg = cfg[`EMB_CFG_ADDR_REG];
	wire cfg_out_reg  = cfg[`EMB_CFG_OUT_REG];
	wire cfg_we_glb   = cfg[`EMB_CFG_WE_GLOBAL];
	wire cfg_lookup   = cfg[`EMB_CFG_LOOKUP];

	// Input path registers
	logic [`EMB_WW-1:0] d_q;    // Registered write data
	logic [`EMB_AW-1:0] a_q;    // Registered address
	logic               we_q;   // Registered write enable

	// Output path
	logic [`EMB_WW-1:0] out_q;  // Output register
	logic               oe1, oe2; // Output register enable copy

	// Input-side reset release
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rs1   <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rs1   <= 1'b1;
			rst_n <= rs1;
		end
	end

	// Output-side reset release
	always_ff @(posedge out_clk or negedge nrst) begin
		if (!nrst) begin
			ors1   <= 1'b0;
			orst_n <= 1'b0;
		end else begin
			ors1   <= 1'b1;
			orst_n <= ors1;
		end
	end

	// APB decode
	wire hit_cfg  = (paddr == `EMB_OFS_CFG);
	wire hit_st   = (paddr == `EMB_OFS_STATUS);
	wire hit_la   = (paddr == `EMB_OFS_LOAD_ADDR);
	wire hit_ld   = (paddr == `EMB_OFS_LOAD_DATA);
	wire hit_any  = hit_cfg | hit_st | hit_la | hit_ld;
	wire apb_wr   = psel & penable & pwrite & hit_any;
	wire ld_wr    = apb_wr & hit_ld;
	wire [31:0] rd_mux = hit_cfg ? {24'h00_0000, cfg} :
	                     hit_st  ? {15'h0000, cfg_lookup, wr_count} :
	                     hit_la  ? {21'h00_0000, load_addr} :
	                     hit_ld  ? {16'h0000, load_data} : 32'h0000_0000;

	// Zero-wait slave; unmapped access flags an error
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit_any;
	assign shape   = emb_pkg::emb_shape_t'(cfg[`EMB_CFG_SHAPE_HI:`EMB_CFG_SHAPE_LO]);

	// Read data captured in the setup cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata <= rd_mux;
		end
	end

	// Configuration register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg <= `EMB_CFG_RESET;
		end else if (apb_wr && hit_cfg) begin
			cfg <= pwdata[7:0];
		end
	end

	// Load pointer: set by software, steps on each loaded word
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			load_addr <= 11'h000;
			load_data <= 16'h0000;
		end else if (apb_wr && hit_la) begin
			load_addr <= pwdata[`EMB_AW-1:0];
		end else if (ld_wr) begin
			load_addr <= load_addr + 11'h001;
			load_data <= pwdata[15:0];
		end
	end

	// Write enable source select
	wire we_src = cfg_we_glb ? user_we_global : user_we;

	// Optional input registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			d_q  <= 16'h0000;
			a_q  <= 11'h000;
			we_q <= 1'b0;
		end else begin
			d_q  <= user_wdata;
			a_q  <= user_addr;
			we_q <= we_src;
		end
	end

	// Registered or direct paths: data chosen alone, enable chosen with address
	wire [`EMB_WW-1:0] eff_wdata = cfg_data_reg ? d_q : user_wdata;
	wire [`EMB_AW-1:0] eff_addr  = cfg_addr_reg ? a_q : user_addr;
	wire               eff_we    = cfg_addr_reg ? we_q : we_src;

	// Internal write pulse; lookup contents change only by loading
	wire user_wr  = eff_we & ~cfg_lookup & ~ld_wr;
	wire wr_pulse = user_wr | ld_wr;
	wire [`EMB_AW-1:0] w_addr = ld_wr ? load_addr : eff_addr;
	wire [`EMB_WW-1:0] w_data = ld_wr ? pwdata[15:0] : eff_wdata;

	// Block select bit in deep mode, just above one block's depth; 2048x1 has none and always picks block 0
	function automatic logic blk_of(input emb_pkg::emb_shape_t s, input logic [`EMB_AW-1:0] a);
		logic r;
		r = 1'b0;
		unique case (s)
			emb_pkg::SHAPE_256X8:  r = a[8];
			emb_pkg::SHAPE_512X4:  r = a[9];
			emb_pkg::SHAPE_1024X2: r = a[10];
			emb_pkg::SHAPE_2048X1: r = 1'b0;
		endcase
		return r;
	endfunction

	wire w_sel = blk_of(shape, w_addr);
	wire r_sel = blk_of(shape, eff_addr);

	// Wide mode writes both, deep mode one
	wire [1:0] blk_we = {wr_pulse & (~cfg_deep | w_sel), wr_pulse & (~cfg_deep | ~w_sel)};

	// Block instances
	logic [`EMB_LANES-1:0] blk_rd [`EMB_BLOCKS];
	genvar gb;
	generate
		for (gb = 0; gb < `EMB_BLOCKS; gb++) begin : g_blk
			emb_ram_array u_arr (
				.clk   (clk),
				.rst_n (rst_n),
				.shape (shape),
				.waddr (w_addr),
				.wdata (cfg_deep ? w_data[7:0] : w_data[gb*8 +: 8]),
				.we    (blk_we[gb]),
				.raddr (eff_addr),
				.rdata (blk_rd[gb])
			);
		end
	endgenerate

	// Combined read word, no extra stage in deep mode
	wire [`EMB_WW-1:0] read_word = cfg_deep ? {8'h00, r_sel ? blk_rd[1] : blk_rd[0]}
	                                        : {blk_rd[1], blk_rd[0]};

	// Write pulse counter for status
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_count <= 16'h0000;
		end else if (wr_pulse) begin
			wr_count <= wr_count + 16'h0001;
		end
	end

	// Output-register enable brought into the output clock domain
	always_ff @(posedge out_clk or negedge orst_n) begin
		if (!orst_n) begin
			oe1 <= 1'b0;
			oe2 <= 1'b0;
		end else begin
			oe1 <= cfg_out_reg;
			oe2 <= oe1;
		end
	end

	// Output register on its own clock
	always_ff @(posedge out_clk or negedge orst_n) begin
		if (!orst_n) begin
			out_q <= 16'h0000;
		end else begin
			out_q <= read_word;
		end
	end

	// Registered or direct read data
	assign user_rdata = oe2 ? out_q : read_word;

	// Assertions
	a_out_reg_lat: assert property (@(posedge out_clk) disable iff (!orst_n)
		(oe2 && $past(oe2)) |-> (user_rdata == $past(read_word)))
		else $error("registered read not one edge late");

	a_out_direct: assert property (@(posedge out_clk) disable iff (!orst_n)
		!oe2 |-> (user_rdata == read_word))
		else $error("direct read not following address");

	a_lookup_hold: assert property (@(posedge clk) disable iff (!rst_n)
		(cfg_lookup && !ld_wr) |-> (blk_we == 2'b00))
		else $error("lookup contents written by user");

	a_we_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		(!cfg_addr_reg && !cfg_lookup && we_src && !ld_wr) |-> (blk_we != 2'b00))
		else $error("no internal write pulse");

	a_addr_reg: assert property (@(posedge clk) disable iff (!rst_n)
		(cfg_addr_reg && $past(cfg_addr_reg)) |-> (eff_addr == $past(user_addr) && eff_we == $past(we_src)))
		else $error("address register path wrong");

	a_data_reg: assert property (@(posedge clk) disable iff (!rst_n)
		(cfg_data_reg && $past(rst_n)) |-> (eff_wdata == $past(user_wdata)))
		else $error("data register path wrong");

	a_we_select: assert property (@(posedge clk) disable iff (!rst_n)
		cfg_we_glb |-> (we_src == user_we_global))
		else $error("global write enable not selected");

	a_wide_both: assert property (@(posedge clk) disable iff (!rst_n)
		(!cfg_deep && wr_pulse) |-> (blk_we == 2'b11))
		else $error("wide write missed a block");

	a_deep_one: assert property (@(posedge clk) disable iff (!rst_n)
		(cfg_deep && wr_pulse) |-> (blk_we == 2'b01 || blk_we == 2'b10))
		else $error("deep write hit two blocks");

	c_deep_wr: cover property (@(posedge clk) disable iff (!rst_n) cfg_deep && blk_we[1]);
	c_wide_wr: cover property (@(posedge clk) disable iff (!rst_n) !cfg_deep && user_wr);
	c_load_wr: cover property (@(posedge clk) disable iff (!rst_n) cfg_lookup && ld_wr);
	c_out_reg: cover property (@(posedge out_clk) disable iff (!orst_n) oe2 && user_rdata != 16'h0000);

endmodule // emb_mem_block

/* File: emb_user_model.sv */
/*
 * Model of the user logic that drives the memory's user port.
 * Assumes the memory samples this port on the rising edge of clk.
 */
`timescale 1ns/10ps
`include "emb_params.svh"

module emb_user_model (
	// Input-side clock
	input  wire logic           clk,
	// User port
	output logic [`EMB_AW-1:0]  user_addr,
	output logic [`EMB_WW-1:0]  user_wdata,
	output logic                user_we,
	output logic                user_we_global
);
	// Idle port at time zero
	initial begin
		user_addr = '0;
		user_wdata = '0;
		user_we = 1'b0;
		user_we_global = 1'b0;
	end

	// One write: address and data lead the enable by one edge, so a registered
	// data path alone (enable unregistered) still captures the new word
	task automatic wr(input logic [10:0] a, input logic [15:0] d, input logic g);
		@(posedge clk);
		user_addr <= a;
		user_wdata <= d;
		@(posedge clk);
		user_we <= 1'b1;
		user_we_global <= g;
		@(posedge clk);
		user_we <= 1'b0;
		user_we_global <= 1'b0;
	endtask

	// Read address; stale write data is inverted so it never looks held
	task automatic rd(input logic [10:0] a);
		@(posedge clk);
		user_addr <= a;
		user_wdata <= ~user_wdata;
	endtask
endmodule // emb_user_model

/* File: configurable_sync_ram_block_test.sv */
/*
 * Self-checking bench of the embedded memory block.
 * Assumes the user port model and the block's package and header.
 */
`timescale 1ns/10ps
`include "emb_params.svh"

module configurable_sync_ram_block_test;
	logic               clk, out_clk, nrst;  // Clocks and reset
	logic [7:0]         paddr;               // APB request
	logic               psel, penable, pwrite;
	logic [31:0]        pwdata, prdata, rv;
	logic               pready, pslverr, ev;
	logic [10:0]        ua, a1;              // User side
	logic [15:0]        uwd, urd, d1, d2, m;
	logic               uwe, uweg;
	int                 mismatches, cmp_count, w;
	logic [31:0]        seed = 32'h0001_3208; // Random state, 78344

	// Clocks: out_clk unrelated in phase and rate
	initial begin clk = 0; forever #10 clk = ~clk; end
	initial begin out_clk = 0; #3; forever #13.5 out_clk = ~out_clk; end

	emb_user_model usr (.clk(clk), .user_addr(ua), .user_wdata(uwd), .user_we(uwe), .user_we_global(uweg));
	emb_mem_block uut (.clk(clk), .out_clk(out_clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .user_addr(ua),
		.user_wdata(uwd), .user_we(uwe), .user_we_global(uweg), .user_rdata(urd));

	// Xorshift source
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Count and report one comparison
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Verdict and end of run
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// One APB transfer, held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin mismatches++; results(); end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Read the user port once settled on both clocks
	task automatic urd_chk(input logic [10:0] a, input logic [15:0] e);
		usr.rd(a);
		repeat (3) @(posedge clk);
		repeat (3) @(posedge out_clk);
		#1 chk("user_rdata", {16'h0000, e}, {16'h0000, urd});
	endtask

	// Main sequence
	initial begin
		nrst = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		// Reset value and unmapped refusal
		apb(0, `EMB_OFS_CFG, 0, rv, ev);
		chk("cfg", {24'h00_0000, `EMB_CFG_RESET}, rv);
		apb(0, 8'h10, 0, rv, ev);
		chk("pslverr", 32'h0000_0001, {31'h0, ev});
		chk("unmapped_rd", 32'h0000_0000, rv);
		$display("test reset done");
		// Every shape, wide pairing
		for (int s = 0; s < 4; s++) begin
			apb(1, `EMB_OFS_CFG, s, rv, ev);
			w = 8 >> s;
			m = (16'h0001 << w) - 16'h0001;
			d1 = 16'(rnd());
			a1 = 11'(rnd());
			usr.wr(a1, d1, 0);
			urd_chk(a1, d1 & (m | (m << 8)));
		end
		$display("test shapes done");
		// Deep cascade: address bit 8 picks block
		apb(1, `EMB_OFS_CFG, 32'h0000_0004, rv, ev);
		d1 = 16'(rnd());
		d2 = 16'(rnd());
		usr.wr(11'h035, d1, 0);
		usr.wr(11'h135, d2, 0);
		urd_chk(11'h035, d1 & 16'h00FF);
		urd_chk(11'h135, d2 & 16'h00FF);
		$display("test deep done");
		// Every register option; status counts write pulses
		apb(0, `EMB_OFS_STATUS, 0, rv, ev);
		d2 = rv[15:0];
		for (int k = 0; k < 8; k++) begin
			apb(1, `EMB_OFS_CFG, k << 3, rv, ev);
			d1 = 16'(rnd());
			a1 = 11'(11'h0A0 + k);
			usr.wr(a1, d1, 0);
			urd_chk(a1, d1);
		end
		apb(0, `EMB_OFS_STATUS, 0, rv, ev);
		chk("write_count", {16'h0, d2 + 16'd8}, {16'h0, rv[15:0]});
		$display("test options done");
		// Global write enable selection
		apb(1, `EMB_OFS_CFG, 32'h0000_0040, rv, ev);
		d1 = 16'(rnd());
		usr.wr(11'h042, d1, 1);
		usr.wr(11'h042, ~d1, 0);
		urd_chk(11'h042, d1);
		$display("test global enable done");
		// Lookup mode: loaded word read back, user write ignored
		d1 = 16'(rnd());
		apb(1, `EMB_OFS_LOAD_ADDR, 32'h0000_0077, rv, ev);
		apb(1, `EMB_OFS_LOAD_DATA, {16'h0, d1}, rv, ev);
		apb(0, `EMB_OFS_LOAD_ADDR, 0, rv, ev);
		chk("load_addr", 32'h0000_0078, rv);
		apb(0, `EMB_OFS_LOAD_DATA, 0, rv, ev);
		chk("load_data", {16'h0000, d1}, rv);
		apb(1, `EMB_OFS_CFG, 32'h0000_0080, rv, ev);
		usr.wr(11'h077, ~d1, 0);
		urd_chk(11'h077, d1);
		apb(0, `EMB_OFS_STATUS, 0, rv, ev);
		chk("lookup_flag", 32'h0000_0001, {31'h0, rv[16]});
		$display("test lookup done");
		results();
	end
endmodule // configurable_sync_ram_block_test
